//--- psa_position_scaling_io.sv
// Position scaling registers, unit converter and local I/O function logic.
`timescale 1ns/10ps
module psa_position_scaling_io
    import psa_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [15:0] paramAddr,
    input  wire logic        paramWrite,
    input  wire logic        paramRead,
    input  wire logic [31:0] paramWData,
    output logic      [31:0] paramRData,
    output logic             paramAck,
    output logic             paramErr,
    input  wire logic        powerStageEnabled,
    input  wire logic        powerOnLoad,
    input  wire logic        convStart,
    input  wire logic        convToUser,
    input  wire logic [31:0] convValue,
    output logic      [31:0] convResult,
    output logic             convDone,
    output logic             convRange,
    output logic             scaleBelowResolution,
    input  wire logic        standstill,
    input  wire logic        deviationRaw,
    output logic             deviationError,
    input  wire logic [3:0]  ioIn,
    output logic      [3:0]  ioOut,
    output logic      [3:0]  ioOe,
    input  wire logic [3:0]  outputFreeLevel,
    input  wire logic        noFault,
    input  wire logic        driveActive,
    output logic             positiveTravelLimit,
    output logic             negativeTravelLimit,
    output logic             referenceSwitch,
    output logic             faultResetRequest,
    output logic             enableRequest,
    output logic             haltRequest,
    output logic             jogPositive,
    output logic             jogNegative,
    output logic             jogFast
);
    logic [31:0]      numStored;
    logic [31:0]      denStored;
    logic [31:0]      activeNum;
    logic [31:0]      activeDen;
    logic [3:0][15:0] fnPending;
    logic [3:0][15:0] fnActive;
    logic [3:0]       ioMeta;
    logic [3:0]       ioSync;
    logic [3:0]       levelStatus;
    logic [3:0]       hitFn;
    logic             hitNum;
    logic             hitDen;
    logic             hitLevel;
    logic             scaleOk;
    logic [3:0]       fnOk;
    logic [3:0]       fnWrite;
    logic             numWrite;
    logic             denWrite;
    logic             mapped;
    logic [31:0]      readMux;
    psa_conv_e        convState;
    logic [6:0]       divCount;
    logic             convNeg;
    logic             convDir;
    logic [31:0]      convMag;
    logic [30:0]      opNum;
    logic [30:0]      opDen;
    logic [79:0]      dvd;
    logic [47:0]      dvs;
    logic [47:0]      rem;
    logic [48:0]      remShift;
    logic             remFits;
    logic [31:0]      limitMag;

    // Legal function codes per line; travel limits are pinned to one line.
    function automatic logic codeLegal(input int line,
                                       input logic [15:0] code);
        logic ok;
        ok = 1'b0;
        unique case (code)
            PSA_FN_FREE, PSA_FN_FRST, PSA_FN_ENA, PSA_FN_HALT,
            PSA_FN_JOGP, PSA_FN_JOGN, PSA_FN_JOGF, PSA_FN_REF,
            PSA_FN_OFREE, PSA_FN_ONF, PSA_FN_OACT: ok = 1'b1;
            PSA_FN_POSITIVE_TRAVEL_LIMIT: ok = (line == 0);
            PSA_FN_NEGATIVE_TRAVEL_LIMIT: ok = (line == 1);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // Address decode and acceptance checks for the parameter port.
    always_comb begin
        hitNum   = (paramAddr == PSA_OFS_NUM);
        hitDen   = (paramAddr == PSA_OFS_DENOM);
        hitLevel = (paramAddr == PSA_OFS_LEVEL);
        scaleOk  = !powerStageEnabled && !paramWData[31] &&
                   (paramWData != 32'h00000000);
        numWrite = paramWrite && hitNum && scaleOk;
        denWrite = paramWrite && hitDen && scaleOk;
        mapped   = hitNum || hitDen || hitLevel || (|hitFn);
    end

    // Per line decode of function register addresses and legal writes.
    for (genvar i = 0; i < PSA_LINES; i++) begin : g_fnDecode
        localparam logic [15:0] LINE_OFS =
            PSA_OFS_FN0 + 16'(i) * PSA_OFS_FN_STP;
        assign hitFn[i] = (paramAddr == LINE_OFS);
        assign fnOk[i] = !powerStageEnabled &&
                         (paramWData[31:16] == 16'h0000) &&
                         codeLegal(i, paramWData[15:0]);
        assign fnWrite[i] = paramWrite && hitFn[i] && fnOk[i];
    end

    // Read data selection; the level word sits in the low four bits.
    always_comb begin
        readMux = 32'h00000000;
        if (hitNum) begin
            readMux = numStored;
        end else if (hitDen) begin
            readMux = denStored;
        end else if (hitLevel) begin
            readMux = {28'h0000000, levelStatus};
        end
        for (int i = 0; i < PSA_LINES; i++) begin
            if (hitFn[i]) begin
                readMux = {16'h0000, fnPending[i]};
            end
        end
    end

    // One answer per request, one cycle later; unmapped or refused is error.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            paramAck   <= 1'b0;
            paramErr   <= 1'b0;
            paramRData <= 32'h00000000;
        end else begin
            paramAck <= 1'b0;
            paramErr <= 1'b0;
            if (paramRead) begin
                paramAck   <= mapped;
                paramErr   <= !mapped;
                paramRData <= readMux;
            end else if (paramWrite) begin
                paramAck <= numWrite || denWrite || (|fnWrite);
                paramErr <= !(numWrite || denWrite || (|fnWrite));
            end
        end
    end

    // Stored scaling values; a refused write leaves them alone.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            numStored <= PSA_NUM_RESET;
            denStored <= PSA_DEN_RESET;
        end else begin
            if (numWrite) begin
                numStored <= paramWData;
            end
            if (denWrite) begin
                denStored <= paramWData;
            end
        end
    end

    // The ratio in use changes only when the numerator is written.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            activeNum <= PSA_NUM_RESET;
            activeDen <= PSA_DEN_RESET;
        end else if (numWrite) begin
            activeNum <= paramWData;
            activeDen <= denStored;
        end
    end

    // Function assignments: stored now, applied at the next power-on.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fnPending <= PSA_FN_FACTORY;
            fnActive  <= PSA_FN_FACTORY;
        end else begin
            for (int i = 0; i < PSA_LINES; i++) begin
                if (fnWrite[i]) begin
                    fnPending[i] <= paramWData[15:0];
                end
            end
            if (powerOnLoad) begin
                fnActive <= fnPending;
            end
        end
    end

    // Pins come from outside the clock domain and pass two flops first.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ioMeta <= 4'h0;
            ioSync <= 4'h0;
        end else begin
            ioMeta <= ioIn;
            ioSync <= ioMeta;
        end
    end

    // Per line pin drive and free input level.
    for (genvar i = 0; i < PSA_LINES; i++) begin : g_line
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                ioOe[i]        <= 1'b0;
                ioOut[i]       <= 1'b0;
                levelStatus[i] <= 1'b0;
            end else begin
                ioOe[i]  <= (fnActive[i] == PSA_FN_OFREE) ||
                            (fnActive[i] == PSA_FN_ONF) ||
                            (fnActive[i] == PSA_FN_OACT);
                ioOut[i] <= ((fnActive[i] == PSA_FN_OFREE) &&
                             outputFreeLevel[i]) ||
                            ((fnActive[i] == PSA_FN_ONF) && noFault) ||
                            ((fnActive[i] == PSA_FN_OACT) && driveActive);
                levelStatus[i] <= ioSync[i] &&
                                  (fnActive[i] == PSA_FN_FREE);
            end
        end
    end

    // Input functions gathered from whichever line carries them.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            positiveTravelLimit <= 1'b0;
            negativeTravelLimit <= 1'b0;
            referenceSwitch     <= 1'b0;
            faultResetRequest   <= 1'b0;
            enableRequest       <= 1'b0;
            haltRequest         <= 1'b0;
            jogPositive         <= 1'b0;
            jogNegative         <= 1'b0;
            jogFast             <= 1'b0;
        end else begin
            positiveTravelLimit <= ioSync[0] &&
                                   (fnActive[0] == PSA_FN_POSITIVE_TRAVEL_LIMIT);
            negativeTravelLimit <= ioSync[1] &&
                                   (fnActive[1] == PSA_FN_NEGATIVE_TRAVEL_LIMIT);
            referenceSwitch   <= |(ioSync & fnIs(PSA_FN_REF));
            faultResetRequest <= |(ioSync & fnIs(PSA_FN_FRST));
            enableRequest     <= |(ioSync & fnIs(PSA_FN_ENA));
            haltRequest       <= |(ioSync & fnIs(PSA_FN_HALT));
            jogPositive       <= |(ioSync & fnIs(PSA_FN_JOGP));
            jogNegative       <= |(ioSync & fnIs(PSA_FN_JOGN));
            jogFast           <= |(ioSync & fnIs(PSA_FN_JOGF));
        end
    end

    // Mask of lines whose active function equals the given code.
    function automatic logic [3:0] fnIs(input logic [15:0] code);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < PSA_LINES; i++) begin
            m[i] = (fnActive[i] == code);
        end
        return m;
    endfunction

    // Detent rest positions make a deviation that must not be reported.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            deviationError <= 1'b0;
        end else begin
            deviationError <= deviationRaw && !standstill;
        end
    end

    // Flag ratios finer than one internal increment per user unit.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scaleBelowResolution <= 1'b0;
        end else begin
            scaleBelowResolution <=
                (48'(activeNum[30:0]) << PSA_RES_SHIFT) <
                48'(activeDen[30:0]);
        end
    end

    // Restoring divider step: shift in one dividend bit.
    always_comb begin
        remShift = {rem, dvd[PSA_DVD_W-1]};
        remFits  = remShift >= {1'b0, dvs};
        limitMag = convNeg ? PSA_NEG_MAX : PSA_POS_MAX;
    end

    // Converter: user to internal is v*num*32768/den, the reverse divides.
    // Eighty serial steps keep the area small at the cost of latency.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            convState  <= CONV_IDLE;
            divCount   <= 7'h00;
            convNeg    <= 1'b0;
            convDir    <= 1'b0;
            convMag    <= 32'h00000000;
            opNum      <= 31'h00000000;
            opDen      <= 31'h00000000;
            dvd        <= 80'h0;
            dvs        <= 48'h0;
            rem        <= 48'h0;
            convResult <= 32'h00000000;
            convDone   <= 1'b0;
            convRange  <= 1'b0;
        end else begin
            convDone <= 1'b0;
            unique case (convState)
                CONV_IDLE: begin
                    if (convStart) begin
                        convNeg   <= convValue[31];
                        convDir   <= convToUser;
                        convMag   <= convValue[31] ? (~convValue + 32'h1)
                                                   : convValue;
                        opNum     <= activeNum[30:0];
                        opDen     <= activeDen[30:0];
                        convState <= CONV_MUL;
                    end
                end
                CONV_MUL: begin
                    if (convDir) begin
                        dvd <= 80'(64'(convMag) * 64'(opDen));
                        dvs <= 48'(opNum) << PSA_RES_SHIFT;
                    end else begin
                        dvd <= 80'(64'(convMag) * 64'(opNum))
                               << PSA_RES_SHIFT;
                        dvs <= 48'(opDen);
                    end
                    rem       <= 48'h0;
                    divCount  <= 7'h00;
                    convState <= CONV_DIV;
                end
                CONV_DIV: begin
                    rem <= remFits ? 48'(remShift - {1'b0, dvs})
                                   : remShift[47:0];
                    dvd <= {dvd[PSA_DVD_W-2:0], remFits};
                    divCount <= divCount + 7'h01;
                    if (divCount == PSA_DIV_LAST) begin
                        convState <= CONV_DONE;
                    end
                end
                CONV_DONE: begin
                    convDone  <= 1'b1;
                    convState <= CONV_IDLE;
                    if (dvd > 80'(limitMag)) begin
                        convRange  <= 1'b1;
                        convResult <= convNeg ? PSA_NEG_MAX : PSA_POS_MAX;
                    end else begin
                        convRange  <= 1'b0;
                        convResult <= convNeg ? (~dvd[31:0] + 32'h1)
                                              : dvd[31:0];
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_write_refused: assert property (
        paramWrite && !paramRead && powerStageEnabled |=> paramErr)
        else $error("Write with power stage enabled was accepted.");
    a_num_applies: assert property (
        numWrite |=> activeNum == $past(paramWData) &&
                     activeDen == $past(denStored))
        else $error("Numerator write did not apply the ratio.");
    a_den_waits: assert property (
        denWrite && !numWrite |=> $stable(activeDen))
        else $error("Denominator write changed the active ratio.");
    a_zero_refused: assert property (
        paramWrite && !paramRead && hitNum &&
        paramWData == 32'h0 |=> paramErr && $stable(numStored))
        else $error("Zero numerator was stored.");
    a_positive_travel_limit_line: assert property (
        paramWrite && !paramRead && (|hitFn[3:1]) &&
        paramWData == 32'(PSA_FN_POSITIVE_TRAVEL_LIMIT) |=> paramErr)
        else $error("Positive limit accepted off line one.");
    a_fn_deferred: assert property (
        fnWrite[0] && !powerOnLoad |=> $stable(fnActive))
        else $error("Function write took effect before power-on.");
    a_detent_quiet: assert property (
        standstill |=> !deviationError)
        else $error("Deviation reported at standstill.");
    a_conv_bound: assert property (
        convState == CONV_IDLE && convStart |-> ##[82:83] convDone)
        else $error("Conversion did not finish in time.");
    a_free_level: assert property (
        fnActive[0] != PSA_FN_FREE |=> !levelStatus[0])
        else $error("Level reported for a non-free line.");

    c_num_write: cover property (numWrite ##1 paramAck);
    c_conv_sat: cover property (convDone && convRange);
    c_fn_apply: cover property (fnWrite[0] ##[1:20] powerOnLoad);
endmodule

//--- psa_pkg.sv
// Constants, register map and types for position scaling and I/O assignment.
// Notes on behaviour
// - Scaling factor is motor revolutions over user units; converts both ways.
// - A new ratio applies on numerator write; denominator waits for it.
// - Internal positions use 32768 increments per revolution, whatever the scaling.
// - Below one revolution per 32768 units, no move may leave the range.
// - Factory scaling is one revolution per twelve user units.
// - Numerator is signed 32-bit, range 1 to 2147483647, default 1.
// - Denominator is signed 32-bit, range 1 to 2147483647, default 12.
// - Scaling writes accepted only with power stage disabled.
// - Accepted numerator write takes effect at once, no power cycle.
// - Converted limit values may come back smaller than written.
// - Standstill detent deviation is ignored and never reported.
// - Factory lines: positive limit, negative limit, free input, reference.
// - Positive limit only on line one, negative only on line two.
// - Free input lines report their level in a readable status.
// - Each line takes one input function or one output function.
// - Function codes: 1,2,3,4,9-11,20,21,22,101-103, 16 bits wide.
// - Function writes need power stage off; apply at next power-on.
package psa_pkg;
    localparam int PSA_LINES  = 4;
    localparam int PSA_ADDR_W = 16;
    localparam int PSA_DATA_W = 32;
    localparam int PSA_FN_W   = 16;

    localparam logic [15:0] PSA_OFS_DENOM  = 16'h060E;
    localparam logic [15:0] PSA_OFS_NUM    = 16'h0610;
    localparam logic [15:0] PSA_OFS_FN0    = 16'h0722;
    localparam logic [15:0] PSA_OFS_FN_STP = 16'h0002;
    localparam logic [15:0] PSA_OFS_LEVEL  = 16'h0800;

    localparam logic [31:0] PSA_NUM_RESET = 32'h00000001;
    localparam logic [31:0] PSA_DEN_RESET = 32'h0000000C;
    localparam logic [31:0] PSA_POS_MAX   = 32'h7FFFFFFF;
    localparam logic [31:0] PSA_NEG_MAX   = 32'h80000000;

    // 32768 increments per revolution, applied as a shift.
    localparam int PSA_RES_SHIFT = 15;

    localparam logic [15:0] PSA_FN_FREE  = 16'h0001;
    localparam logic [15:0] PSA_FN_FRST  = 16'h0002;
    localparam logic [15:0] PSA_FN_ENA   = 16'h0003;
    localparam logic [15:0] PSA_FN_HALT  = 16'h0004;
    localparam logic [15:0] PSA_FN_JOGP  = 16'h0009;
    localparam logic [15:0] PSA_FN_JOGN  = 16'h000A;
    localparam logic [15:0] PSA_FN_JOGF  = 16'h000B;
    localparam logic [15:0] PSA_FN_REF   = 16'h0014;
    localparam logic [15:0] PSA_FN_POSITIVE_TRAVEL_LIMIT  = 16'h0015;
    localparam logic [15:0] PSA_FN_NEGATIVE_TRAVEL_LIMIT  = 16'h0016;
    localparam logic [15:0] PSA_FN_OFREE = 16'h0065;
    localparam logic [15:0] PSA_FN_ONF   = 16'h0066;
    localparam logic [15:0] PSA_FN_OACT  = 16'h0067;

    // Factory assignment, line four down to line one.
    localparam logic [3:0][15:0] PSA_FN_FACTORY =
        {PSA_FN_REF, PSA_FN_FREE, PSA_FN_NEGATIVE_TRAVEL_LIMIT, PSA_FN_POSITIVE_TRAVEL_LIMIT};

    localparam int         PSA_DVD_W = 80;
    localparam int         PSA_DVS_W = 48;
    localparam logic [6:0] PSA_DIV_LAST = 7'h4F;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b00,
        CONV_MUL  = 2'b01,
        CONV_DIV  = 2'b11,
        CONV_DONE = 2'b10
    } psa_conv_e;
endpackage

//--- psa_host_model.sv
// Host model that writes and reads parameters over the parameter port.
`timescale 1ns/10ps
module psa_host_model
(
    input  wire logic        clk,
    input  wire logic [31:0] paramRData,
    input  wire logic        paramAck,
    input  wire logic        paramErr,
    output logic      [15:0] paramAddr,
    output logic             paramWrite,
    output logic             paramRead,
    output logic      [31:0] paramWData
);
    // The port is idle from time zero.
    initial begin
        paramAddr  = 16'h0000;
        paramWrite = 1'b0;
        paramRead  = 1'b0;
        paramWData = 32'h00000000;
    end

    // One request per call, as a one-cycle pulse; the answer is registered
    // by the taking edge and stands for one cycle only, so it is read at
    // the falling edge that follows, before the next edge clears it.
    // host stage discipline
    task automatic access(input logic wr, input logic [15:0] a,
                          input logic [31:0] d, output logic [31:0] rd,
                          output logic ok);
        @(negedge clk);
        paramAddr  = a;
        paramWrite = wr;
        paramRead  = ~wr;
        paramWData = d;
        @(negedge clk);
        rd = paramRData;
        ok = (paramAck === 1'b1) && (paramErr === 1'b0);
        paramWrite = 1'b0;
        paramRead  = 1'b0;
        // Released data is inverted so that a stale capture shows up.
        paramWData = ~d;
    endtask
endmodule

//--- position_scaling_io_assign_test.sv
// Self-checking bench for position scaling and I/O function assignment.
`timescale 1ns/10ps
module position_scaling_io_assign_test
    import psa_pkg::*;
;
    logic        clk, reset, paramWrite, paramRead, paramAck, paramErr;
    logic        powerStageEnabled, powerOnLoad, convStart, convToUser;
    logic        convDone, convRange, scaleBelowResolution, standstill;
    logic        deviationRaw, deviationError, positiveTravelLimit, ok;
    logic [15:0] paramAddr;
    logic [31:0] paramWData, paramRData, convValue, convResult, rd;
    logic        negativeTravelLimit, referenceSwitch, noFault;
    logic [3:0]  ioIn, ioOe, ioOut;
    int          n_fail, checks;

    psa_host_model psa_host_model_i (.clk, .paramRData, .paramAck,
        .paramErr, .paramAddr, .paramWrite, .paramRead, .paramWData);

    psa_position_scaling_io psa_position_scaling_io_i (.clk, .reset,
        .paramAddr, .paramWrite, .paramRead, .paramWData, .paramRData,
        .paramAck, .paramErr, .powerStageEnabled, .powerOnLoad, .convStart,
        .convToUser, .convValue, .convResult, .convDone, .convRange,
        .scaleBelowResolution, .standstill, .deviationRaw, .deviationError,
        .ioIn, .ioOut, .ioOe, .outputFreeLevel(4'h0), .noFault,
        .driveActive(1'b0), .positiveTravelLimit, .negativeTravelLimit,
        .referenceSwitch, .faultResetRequest(), .enableRequest(),
        .haltRequest(), .jogPositive(), .jogNegative(), .jogFast());

    // Free-running 250 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t %s: %h not %h", $time, msg, got,
                     exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d,
                      input logic expOk);
        psa_host_model_i.access(1'b1, a, d, rd, ok);
        check(32'(ok), 32'(expOk), "write answer");
    endtask

    task automatic rdc(input logic [15:0] a, input logic [31:0] exp);
        psa_host_model_i.access(1'b0, a, 32'h00000000, rd, ok);
        check(rd, exp, "read value");
    endtask

    // Start a conversion and wait a bounded time for its result.
    task automatic conv(input logic tu, input logic [31:0] v,
                        input logic [31:0] exp);
        int n;
        @(negedge clk);
        convStart = 1'b1;
        convToUser = tu;
        convValue = v;
        @(negedge clk);
        convStart = 1'b0;
        n = 0;
        while (convDone !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        // Done is seen at the 82nd falling edge after the release.
        check(32'(n), 32'h00000052, "latency");
        check(convResult, exp, "conversion");
    endtask

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic t_factory;
        logic [15:0] fac [4];
        fac = '{16'h0015, 16'h0016, 16'h0001, 16'h0014};
        rdc(PSA_OFS_NUM, 32'h00000001);
        rdc(PSA_OFS_DENOM, 32'h0000000C);
        for (int i = 0; i < 4; i++) begin
            rdc(PSA_OFS_FN0 + 16'(2 * i), {16'h0000, fac[i]});
        end
        conv(1'b0, 32'h00000001, 32'h00000AAA);
        $display("factory test done");
    endtask

    // A denominator alone must not change the active ratio.
    task automatic t_scale;
        wr(PSA_OFS_DENOM, 32'h00000005, 1'b1);
        conv(1'b0, 32'h00000001, 32'h00000AAA);
        wr(PSA_OFS_NUM, 32'h00000003, 1'b1);
        conv(1'b0, 32'h00000001, 32'h00004CCC);
        conv(1'b1, 32'h00008000, 32'h00000001);
        // A negative operand truncates toward zero as well.
        conv(1'b0, 32'hFFFFFFFF, 32'hFFFFB334);
        $display("scaling test done");
    endtask

    task automatic t_refuse;
        powerStageEnabled = 1'b1;
        wr(PSA_OFS_NUM, 32'h00000007, 1'b0);
        wr(PSA_OFS_FN0, 32'h00000001, 1'b0);
        powerStageEnabled = 1'b0;
        rdc(PSA_OFS_NUM, 32'h00000003);
        wr(PSA_OFS_NUM, 32'h00000000, 1'b0);
        wr(PSA_OFS_DENOM, 32'h80000000, 1'b0);
        wr(PSA_OFS_LEVEL, 32'h00000001, 1'b0);
        rdc(PSA_OFS_DENOM, 32'h00000005);
        $display("refusal test done");
    endtask

    // Saturation at the top of the range, then the resolution boundary.
    task automatic t_range;
        wr(PSA_OFS_NUM, 32'h7FFFFFFF, 1'b1);
        conv(1'b0, 32'h00000001, 32'h7FFFFFFF);
        check(32'(convRange), 32'h00000001, "range flag");
        wr(PSA_OFS_DENOM, 32'h00008001, 1'b1);
        wr(PSA_OFS_NUM, 32'h00000001, 1'b1);
        repeat (2) @(negedge clk);
        check(32'(scaleBelowResolution), 32'h00000001, "below");
        wr(PSA_OFS_DENOM, 32'h00008000, 1'b1);
        wr(PSA_OFS_NUM, 32'h00000001, 1'b1);
        repeat (2) @(negedge clk);
        check(32'(scaleBelowResolution), 32'h00000000, "at res");
        $display("range test done");
    endtask

    // Pending functions must wait for the power-on event.
    task automatic t_io;
        logic [15:0] codes [11];
        codes = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0009,
                  16'h000A, 16'h000B, 16'h0014, 16'h0065, 16'h0066, 16'h0067};
        wr(PSA_OFS_FN0 + 16'h0002, 32'h00000015, 1'b0);
        wr(PSA_OFS_FN0, 32'h00000016, 1'b0);
        wr(PSA_OFS_FN0 + 16'h0004, 32'h00000005, 1'b0);
        foreach (codes[i]) begin
            wr(PSA_OFS_FN0 + 16'h0004, 32'(codes[i]), 1'b1);
        end
        // Line three ends as the no-fault output, line one as free input.
        wr(PSA_OFS_FN0 + 16'h0004, 32'h00000066, 1'b1);
        wr(PSA_OFS_FN0, 32'h00000001, 1'b1);
        ioIn = 4'hF;
        repeat (4) @(negedge clk);
        check(32'(positiveTravelLimit), 32'h00000001, "old");
        powerOnLoad = 1'b1;
        @(negedge clk);
        powerOnLoad = 1'b0;
        repeat (4) @(negedge clk);
        check(32'(positiveTravelLimit), 32'h00000000, "new");
        check(32'(negativeTravelLimit), 32'h00000001, "neg");
        check(32'(referenceSwitch), 32'h00000001, "ref");
        check(32'(ioOe), 32'h00000004, "oe");
        check(32'(ioOut), 32'h00000004, "out");
        rdc(PSA_OFS_LEVEL, 32'h00000001);
        rdc(PSA_OFS_FN0 + 16'h0004, 32'h00000066);
        $display("io test done");
    endtask

    task automatic t_detent;
        standstill = 1'b1;
        deviationRaw = 1'b1;
        repeat (2) @(negedge clk);
        check(32'(deviationError), 32'h00000000, "detent");
        standstill = 1'b0;
        repeat (2) @(negedge clk);
        check(32'(deviationError), 32'h00000001, "moving");
        deviationRaw = 1'b0;
        $display("detent test done");
    endtask

    // Main sequence; inputs change only at falling edges.
    initial begin
        n_fail = 0;
        checks = 0;
        reset = 1'b1;
        powerStageEnabled = 1'b0;
        powerOnLoad = 1'b0;
        convStart = 1'b0;
        convToUser = 1'b0;
        convValue = 32'h00000000;
        standstill = 1'b0;
        deviationRaw = 1'b0;
        ioIn = 4'h0;
        noFault = 1'b1;
        repeat (10) @(negedge clk);
        reset = 1'b0;
        t_factory();
        t_scale();
        t_refuse();
        t_range();
        t_io();
        t_detent();
        report_and_stop();
    end

    // The tests need about six hundred cycles; this cuts a hang well beyond.
    initial begin
        #80000;
        n_fail++;
        report_and_stop();
    end
endmodule
